// *** power_seq_params.svh ***
`ifndef POWER_SEQ_PARAMS_SVH
`define POWER_SEQ_PARAMS_SVH

`define RUN_SETTINGS_OFS 8'h18
`define FIRST_SLEEP_SETTINGS_OFS 8'h1c
`define SECOND_SLEEP_SETTINGS_OFS 8'h20
`define SEQUENCE_STATUS_OFS 8'h24

`define DWELL_MSB 20
`define DWELL_LSB 16
`define TILE_CLOCK_STOP_BIT 14
`define ANALOG_PFM_BIT 9
`define CORE_PFM_BIT 8
`define IO_SUPPLY_EN_BIT 5
`define PLL_REG_EN_BIT 4
`define ANALOG_EN_BIT 1
`define CORE_EN_BIT 0

`define STATE_MSB 18
`define STATE_LSB 16
`define PREV_IO_BIT 29
`define PREV_PLL_BIT 28
`define PREV_ANALOG_BIT 25
`define PREV_CORE_BIT 24

`define RUN_WRITE_MASK 32'h0000_4331
`define SLEEP_WRITE_MASK 32'h001f_4331
`define SETTINGS_FIXED_ONES 32'h0000_0002

`define RUN_SETTINGS_RESET 32'h0000_0033
`define FIRST_SLEEP_SETTINGS_RESET 32'h0010_0022
`define SECOND_SLEEP_SETTINGS_RESET 32'h0010_0002
`define PREV_FLAGS_RESET 4'h2

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// *** power_seq_pkg.sv ***
package power_seq_pkg;

    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_ASLEEP = 3'b001,
        ST_FIRST_WAKE = 3'b010,
        ST_SECOND_WAKE = 3'b011,
        ST_AWAKE_WAIT = 3'b100,
        ST_AWAKE = 3'b101,
        ST_FIRST_SLEEP = 3'b110,
        ST_SECOND_SLEEP = 3'b111
    } seq_state_t;

    typedef logic [31:0] word_t;

    typedef logic [4:0] dwell_exp_t;

endpackage

// *** dwell_timer.sv ***
`timescale 1ns/1ns
module dwell_timer
    import power_seq_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic load,
    input wire dwell_exp_t exponent,
    output logic done
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] span;

    // Loaded value 2**N - 1 gives exactly 2**N cycles in the state
    assign span = ({{(CNT_W-1){1'b0}}, 1'b1} << exponent) - {{(CNT_W-1){1'b0}}, 1'b1};
    assign cnt_d = load ? span : ((cnt_q == '0) ? cnt_q : cnt_q - {{(CNT_W-1){1'b0}}, 1'b1});
    assign done = (cnt_q == '0);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// *** power_state_supply_control.sv ***
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`include "power_seq_params.svh"
module power_state_supply_control
    import power_seq_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DWELL_CNT_W = 32
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] asleep_settings,
    input wire logic [31:0] first_wake_settings,
    input wire logic [31:0] second_wake_settings,
    input wire logic sleep_request,
    input wire logic wake_pin,
    input wire logic core_supply_good_pin,
    input wire logic analog_supply_good_pin,
    input wire logic io_supply_good_pin,
    input wire logic pll_supply_good_pin,
    output logic core_buck_converter_en,
    output logic analog_buck_converter_en,
    output logic io_supply_output_en,
    output logic pll_linear_regulator_en,
    output logic core_buck_pulse_frequency_modulation,
    output logic analog_buck_pulse_frequency_modulation,
    output logic tile_clock_stop,
    output logic [2:0] sequencer_state
);

    function automatic word_t apply_strobe(input word_t old, input word_t wdata, input logic [3:0] strb,
                                           input word_t mask);
        word_t bytes;
        bytes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        apply_strobe = (old & ~(bytes & mask)) | (wdata & bytes & mask);
    endfunction

    function automatic logic enabled_good(input word_t cfg, input logic [3:0] good);
        enabled_good = (good[0] | ~cfg[`CORE_EN_BIT])
            & (good[1] | ~cfg[`ANALOG_EN_BIT])
            & (good[2] | ~cfg[`IO_SUPPLY_EN_BIT])
            & (good[3] | ~cfg[`PLL_REG_EN_BIT]);
    endfunction

    // Two-stage synchronisers for pins
    logic [4:0] pin_meta_q;
    logic [4:0] pin_sync_q;
    logic wake_sync;
    logic [3:0] supply_good;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_meta_q <= 5'h00;
            pin_sync_q <= 5'h00;
        end else begin
            pin_meta_q <= {wake_pin, pll_supply_good_pin, io_supply_good_pin, analog_supply_good_pin,
                           core_supply_good_pin};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign wake_sync = pin_sync_q[4];
    assign supply_good = pin_sync_q[3:0];

    // Settings registers
    word_t run_supply_settings_q;
    word_t first_sleep_supply_settings_q;
    word_t second_sleep_supply_settings_q;
    word_t run_supply_settings;
    word_t first_sleep_supply_settings;
    word_t second_sleep_supply_settings;

    // Bit 1 is a fixed one, never stored from the bus
    assign run_supply_settings = run_supply_settings_q | `SETTINGS_FIXED_ONES;
    assign first_sleep_supply_settings = first_sleep_supply_settings_q | `SETTINGS_FIXED_ONES;
    assign second_sleep_supply_settings = second_sleep_supply_settings_q | `SETTINGS_FIXED_ONES;

    // AXI4-Lite write path
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] waddr_q;
    word_t wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic do_write;
    logic wr_run;
    logic wr_first_sleep;
    logic wr_second_sleep;
    logic wr_status;
    logic wr_mapped;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;

    assign wr_run = (waddr_q == ADDR_W'(`RUN_SETTINGS_OFS));
    assign wr_first_sleep = (waddr_q == ADDR_W'(`FIRST_SLEEP_SETTINGS_OFS));
    assign wr_second_sleep = (waddr_q == ADDR_W'(`SECOND_SLEEP_SETTINGS_OFS));
    assign wr_status = (waddr_q == ADDR_W'(`SEQUENCE_STATUS_OFS));
    assign wr_mapped = wr_run || wr_first_sleep || wr_second_sleep || wr_status;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            waddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            waddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            w_held_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= `AXI_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            run_supply_settings_q <= `RUN_SETTINGS_RESET;
            first_sleep_supply_settings_q <= `FIRST_SLEEP_SETTINGS_RESET;
            second_sleep_supply_settings_q <= `SECOND_SLEEP_SETTINGS_RESET;
        end else if (do_write) begin
            if (wr_run) begin
                run_supply_settings_q <= apply_strobe(run_supply_settings_q, wdata_q, wstrb_q,
                                                      `RUN_WRITE_MASK);
            end
            if (wr_first_sleep) begin
                first_sleep_supply_settings_q <= apply_strobe(first_sleep_supply_settings_q, wdata_q,
                                                              wstrb_q, `SLEEP_WRITE_MASK);
            end
            if (wr_second_sleep) begin
                second_sleep_supply_settings_q <= apply_strobe(second_sleep_supply_settings_q, wdata_q,
                                                               wstrb_q, `SLEEP_WRITE_MASK);
            end
        end
    end

    // Sequencer
    seq_state_t state_q;
    seq_state_t state_d;
    logic state_change;
    word_t active_cfg;
    word_t next_cfg;
    logic dwell_done;
    logic supplies_ready;

    assign supplies_ready = enabled_good(active_cfg, supply_good);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RESET: begin
                state_d = ST_FIRST_WAKE;
            end
            ST_ASLEEP: begin
                if (wake_sync) begin
                    state_d = ST_FIRST_WAKE;
                end
            end
            ST_FIRST_WAKE: begin
                if (dwell_done && supplies_ready) begin
                    state_d = ST_SECOND_WAKE;
                end
            end
            ST_SECOND_WAKE: begin
                if (dwell_done && supplies_ready) begin
                    state_d = ST_AWAKE_WAIT;
                end
            end
            ST_AWAKE_WAIT: begin
                if (supplies_ready) begin
                    state_d = ST_AWAKE;
                end
            end
            ST_AWAKE: begin
                if (sleep_request) begin
                    state_d = ST_FIRST_SLEEP;
                end
            end
            ST_FIRST_SLEEP: begin
                if (dwell_done) begin
                    state_d = ST_SECOND_SLEEP;
                end
            end
            ST_SECOND_SLEEP: begin
                if (dwell_done) begin
                    state_d = ST_ASLEEP;
                end
            end
        endcase
    end

    assign state_change = (state_d != state_q);

    // Settings in force for a state
    function automatic word_t cfg_of(input seq_state_t st, input word_t run_cfg, input word_t sl1_cfg,
                                     input word_t sl2_cfg, input word_t asl_cfg, input word_t wk1_cfg,
                                     input word_t wk2_cfg);
        unique case (st)
            ST_RESET: cfg_of = `RUN_SETTINGS_RESET;
            ST_ASLEEP: cfg_of = asl_cfg;
            ST_FIRST_WAKE: cfg_of = wk1_cfg;
            ST_SECOND_WAKE: cfg_of = wk2_cfg;
            ST_AWAKE_WAIT: cfg_of = wk2_cfg;
            ST_AWAKE: cfg_of = run_cfg;
            ST_FIRST_SLEEP: cfg_of = sl1_cfg;
            ST_SECOND_SLEEP: cfg_of = sl2_cfg;
        endcase
    endfunction

    assign active_cfg = cfg_of(state_q, run_supply_settings, first_sleep_supply_settings,
                               second_sleep_supply_settings, asleep_settings, first_wake_settings,
                               second_wake_settings);
    assign next_cfg = cfg_of(state_d, run_supply_settings, first_sleep_supply_settings,
                             second_sleep_supply_settings, asleep_settings, first_wake_settings,
                             second_wake_settings);

    dwell_timer #(
        .CNT_W(DWELL_CNT_W)
    ) u_dwell_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(state_change),
        .exponent(next_cfg[`DWELL_MSB:`DWELL_LSB]),
        .done(dwell_done)
    );

    // Applied outputs and previous-state flags
    word_t applied_q;
    logic [3:0] prev_en_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= ST_RESET;
            applied_q <= `RUN_SETTINGS_RESET;
            prev_en_q <= `PREV_FLAGS_RESET;
        end else begin
            state_q <= state_d;
            applied_q <= next_cfg;
            if (state_change) begin
                prev_en_q <= {applied_q[`IO_SUPPLY_EN_BIT], applied_q[`PLL_REG_EN_BIT],
                              applied_q[`ANALOG_EN_BIT], applied_q[`CORE_EN_BIT]};
            end
        end
    end

    assign tile_clock_stop = applied_q[`TILE_CLOCK_STOP_BIT];
    assign analog_buck_pulse_frequency_modulation = applied_q[`ANALOG_PFM_BIT];
    assign core_buck_pulse_frequency_modulation = applied_q[`CORE_PFM_BIT];
    assign io_supply_output_en = applied_q[`IO_SUPPLY_EN_BIT];
    assign pll_linear_regulator_en = applied_q[`PLL_REG_EN_BIT];
    assign analog_buck_converter_en = applied_q[`ANALOG_EN_BIT];
    assign core_buck_converter_en = applied_q[`CORE_EN_BIT];
    assign sequencer_state = state_q;

    // Status word
    word_t status_word;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`PREV_IO_BIT] = prev_en_q[3];
        status_word[`PREV_PLL_BIT] = prev_en_q[2];
        status_word[`PREV_ANALOG_BIT] = prev_en_q[1];
        status_word[`PREV_CORE_BIT] = prev_en_q[0];
        status_word[`STATE_MSB:`STATE_LSB] = state_q;
        status_word[`TILE_CLOCK_STOP_BIT] = applied_q[`TILE_CLOCK_STOP_BIT];
        status_word[`ANALOG_PFM_BIT] = applied_q[`ANALOG_PFM_BIT];
        status_word[`CORE_PFM_BIT] = applied_q[`CORE_PFM_BIT];
        status_word[`IO_SUPPLY_EN_BIT] = applied_q[`IO_SUPPLY_EN_BIT];
        status_word[`PLL_REG_EN_BIT] = applied_q[`PLL_REG_EN_BIT];
        status_word[`ANALOG_EN_BIT] = applied_q[`ANALOG_EN_BIT];
        status_word[`CORE_EN_BIT] = applied_q[`CORE_EN_BIT];
    end

    // AXI4-Lite read path
    logic rvalid_q;
    word_t rdata_q;
    logic [1:0] rresp_q;
    logic rd_run;
    logic rd_first_sleep;
    logic rd_second_sleep;
    logic rd_status;
    logic rd_mapped;
    word_t rd_word;

    assign rd_run = (s_axi_araddr == ADDR_W'(`RUN_SETTINGS_OFS));
    assign rd_first_sleep = (s_axi_araddr == ADDR_W'(`FIRST_SLEEP_SETTINGS_OFS));
    assign rd_second_sleep = (s_axi_araddr == ADDR_W'(`SECOND_SLEEP_SETTINGS_OFS));
    assign rd_status = (s_axi_araddr == ADDR_W'(`SEQUENCE_STATUS_OFS));
    assign rd_mapped = rd_run || rd_first_sleep || rd_second_sleep || rd_status;
    assign rd_word = rd_run ? run_supply_settings :
                     rd_first_sleep ? first_sleep_supply_settings :
                     rd_second_sleep ? second_sleep_supply_settings :
                     rd_status ? status_word : 32'h0000_0000;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `AXI_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

// *** power_state_supply_control_properties.sv ***
`timescale 1ns/1ns
module power_state_supply_control_properties
    import power_seq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] first_wake_settings,
    input wire logic sleep_request,
    input wire logic io_supply_good_pin,
    input wire logic core_buck_converter_en,
    input wire logic analog_buck_converter_en,
    input wire logic io_supply_output_en,
    input wire logic pll_linear_regulator_en,
    input wire logic core_buck_pulse_frequency_modulation,
    input wire logic analog_buck_pulse_frequency_modulation,
    input wire logic tile_clock_stop,
    input wire logic [2:0] sequencer_state
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    logic [6:0] outs_w;
    logic [2:0] succ_w;
    assign outs_w = {tile_clock_stop, analog_buck_pulse_frequency_modulation, core_buck_pulse_frequency_modulation,
                     io_supply_output_en, pll_linear_regulator_en, analog_buck_converter_en, core_buck_converter_en};
    // Only legal successor of each state
    assign succ_w = (sequencer_state == ST_AWAKE) ? ST_FIRST_SLEEP :
                    (sequencer_state == ST_SECOND_SLEEP) ? ST_ASLEEP :
                    (sequencer_state == ST_RESET || sequencer_state == ST_ASLEEP) ? ST_FIRST_WAKE :
                    sequencer_state + 3'h1;

    sequence s_sleep_asked;
        sequencer_state == ST_AWAKE && sleep_request;
    endsequence
    sequence s_supply_low;
        (first_wake_settings[5] && !io_supply_good_pin) [*3];
    endsequence

    property p_reset_outputs;
        $rose(rst_n) |-> sequencer_state == ST_RESET && outs_w == 7'h0f;
    endproperty
    property p_reset_to_wake;
        sequencer_state == ST_RESET && rst_n |=> sequencer_state == ST_FIRST_WAKE;
    endproperty
    property p_succession;
        sequencer_state != ST_RESET |=>
            sequencer_state == $past(sequencer_state) || sequencer_state == $past(succ_w);
    endproperty
    property p_sleep_entry;
        s_sleep_asked |=> sequencer_state == ST_FIRST_SLEEP;
    endproperty
    property p_wake_holds;
        s_supply_low ##0 sequencer_state == ST_FIRST_WAKE |=> sequencer_state == ST_FIRST_WAKE;
    endproperty
    property p_write_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    property p_write_holds;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_read_holds;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty

    a_reset_outputs: assert property (p_reset_outputs) else $error("reset outputs wrong");
    a_reset_to_wake: assert property (p_reset_to_wake) else $error("reset not followed by wake");
    a_succession: assert property (p_succession) else $error("illegal state step");
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep request ignored");
    a_wake_holds: assert property (p_wake_holds) else $error("wake advanced on bad supply");
    a_write_answer: assert property (p_write_answer) else $error("write response late");
    a_write_holds: assert property (p_write_holds) else $error("write response dropped");
    a_read_answer: assert property (p_read_answer) else $error("read data late");
    a_read_holds: assert property (p_read_holds) else $error("read data dropped");
endmodule

bind power_state_supply_control power_state_supply_control_properties u_props (
    .mclk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .first_wake_settings, .sleep_request, .io_supply_good_pin, .core_buck_converter_en, .analog_buck_converter_en,
    .io_supply_output_en, .pll_linear_regulator_en, .core_buck_pulse_frequency_modulation,
    .analog_buck_pulse_frequency_modulation, .tile_clock_stop, .sequencer_state
);

// *** power_state_supply_control_tb_top.sv ***
`timescale 1ns/1ns
`include "power_seq_params.svh"
module power_state_supply_control_tb_top
    import power_seq_pkg::*;
;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] wd;
        logic [1:0] wr;
        logic [31:0] rd;
        logic [1:0] rr;
        logic [6:0] o;
    } row_t;
    logic mclk = 1'b0;
    logic rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleep_request, wake_pin;
    logic core_supply_good_pin, analog_supply_good_pin, io_supply_good_pin, pll_supply_good_pin;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, asleep_settings, first_wake_settings, second_wake_settings, s_axi_rdata, data;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic core_buck_converter_en, analog_buck_converter_en, io_supply_output_en, pll_linear_regulator_en;
    logic core_buck_pulse_frequency_modulation, analog_buck_pulse_frequency_modulation, tile_clock_stop;
    logic [2:0] sequencer_state;
    logic [6:0] outs;
    int err_count = 0;
    int cmp_count = 0;
    row_t rows [0:7];

    assign outs = {tile_clock_stop, analog_buck_pulse_frequency_modulation, core_buck_pulse_frequency_modulation,
                   io_supply_output_en, pll_linear_regulator_en, analog_buck_converter_en, core_buck_converter_en};

    always #10 mclk = ~mclk;

    power_state_supply_control uut (
        .mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .asleep_settings, .first_wake_settings,
        .second_wake_settings, .sleep_request, .wake_pin, .core_supply_good_pin, .analog_supply_good_pin,
        .io_supply_good_pin, .pll_supply_good_pin, .core_buck_converter_en, .analog_buck_converter_en,
        .io_supply_output_en, .pll_linear_regulator_en, .core_buck_pulse_frequency_modulation,
        .analog_buck_pulse_frequency_modulation, .tile_clock_stop, .sequencer_state
    );

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Response ready is raised only after valid is seen, so the slave must hold it
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        repeat (50) begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        chk("write timeout", 32'h0, 32'h1);
    endtask

    task automatic axi_read(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        repeat (50) begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                resp = s_axi_rresp;
                data = s_axi_rdata;
                s_axi_rready <= 1'b0;
                return;
            end
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        chk("read timeout", 32'h0, 32'h1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_read(a);
        chk("read response", 32'h0, 32'(resp));
        chk("read value", exp, data);
    endtask

    task automatic wait_state(input logic [2:0] s);
        repeat (300) begin
            if (sequencer_state === s) return;
            @(posedge mclk);
        end
        chk("state reached", 32'(s), 32'(sequencer_state));
    endtask

    task automatic dwell_chk(input logic [2:0] s, input int cyc, input logic [6:0] o);
        int n;
        n = 0;
        wait_state(s);
        chk("step outputs", 32'(o), 32'(outs));
        do begin
            n++;
            @(posedge mclk);
        end while (sequencer_state === s && n < 300);
        chk("step length", 32'(cyc), 32'(n));
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        chk("watchdog", 32'h0, 32'h1);
        wrap_up;
    end

    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleep_request} = 7'h00;
        {wake_pin, core_supply_good_pin, analog_supply_good_pin, io_supply_good_pin, pll_supply_good_pin} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        asleep_settings = 32'h0000_0002;
        first_wake_settings = 32'h0000_0022;
        second_wake_settings = 32'h0000_0033;
        rows = '{'{8'h18, 32'hffff_ffff, 2'h0, 32'h0000_4333, 2'h0, 7'h7f},
                 '{8'h24, 32'hffff_ffff, 2'h0, 32'h3305_4333, 2'h0, 7'h7f},
                 '{8'h18, 32'h0000_0200, 2'h0, 32'h0000_0202, 2'h0, 7'h22},
                 '{8'h18, 32'h0000_0000, 2'h0, 32'h0000_0002, 2'h0, 7'h02},
                 '{8'h1c, 32'hffff_ffff, 2'h0, 32'h001f_4333, 2'h0, 7'h02},
                 '{8'h1c, 32'h0002_4020, 2'h0, 32'h0002_4022, 2'h0, 7'h02},
                 '{8'h20, 32'h0001_0110, 2'h0, 32'h0001_0112, 2'h0, 7'h02},
                 '{8'h30, 32'hffff_ffff, 2'h2, 32'h0000_0000, 2'h2, 7'h02}};
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (12) @(posedge mclk);
        chk("held in wake", 32'(ST_FIRST_WAKE), 32'(sequencer_state));
        rd_chk(`SEQUENCE_STATUS_OFS, 32'h3302_0022);
        rd_chk(`RUN_SETTINGS_OFS, 32'h0000_0033);
        rd_chk(`FIRST_SLEEP_SETTINGS_OFS, 32'h0010_0022);
        rd_chk(`SECOND_SLEEP_SETTINGS_OFS, 32'h0010_0002);
        $display("test reset values done");
        {core_supply_good_pin, analog_supply_good_pin, io_supply_good_pin, pll_supply_good_pin} <= 4'hf;
        wait_state(ST_AWAKE);
        chk("run outputs", 32'h0000_000f, 32'(outs));
        foreach (rows[i]) begin
            axi_write(rows[i].a, rows[i].wd);
            chk("write response", 32'(rows[i].wr), 32'(resp));
            axi_read(rows[i].a);
            chk("read response", 32'(rows[i].rr), 32'(resp));
            chk("read data", rows[i].rd, data);
            chk("live outputs", 32'(rows[i].o), 32'(outs));
        end
        $display("test register table done");
        sleep_request <= 1'b1;
        wait_state(ST_FIRST_SLEEP);
        sleep_request <= 1'b0;
        dwell_chk(ST_FIRST_SLEEP, 4, 7'h4a);
        dwell_chk(ST_SECOND_SLEEP, 2, 7'h16);
        chk("asleep", 32'(ST_ASLEEP), 32'(sequencer_state));
        chk("asleep outputs", 32'h0000_0002, 32'(outs));
        rd_chk(`SEQUENCE_STATUS_OFS, 32'h1201_0002);
        $display("test sleep sequence done");
        wake_pin <= 1'b1;
        wait_state(ST_FIRST_WAKE);
        wake_pin <= 1'b0;
        wait_state(ST_AWAKE);
        chk("awake again", 32'h0000_0002, 32'(outs));
        s_axi_wstrb <= 4'h2;
        axi_write(`RUN_SETTINGS_OFS, 32'hffff_ffff);
        rd_chk(`RUN_SETTINGS_OFS, 32'h0000_4302);
        $display("test wake done");
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd_chk(`RUN_SETTINGS_OFS, 32'h0000_0033);
        $display("test second reset done");
        wrap_up;
    end
endmodule
